// File: core/odtc_top.sv
// Order decode and timing control of a small stored-program computer.
// Assumes a memory that answers a held read with a one-cycle ack.
//
// Overview of operation
// - Ten-digit program counter, cleared to zero by a control command.
// - Subprogram and conditional jumps load counter from low ten transfer digits.
// - Program counter addresses memory for every order fetch.
// - Six control digits decode into component operations.
// - Zero control digits with nonzero address halt the machine at once, with no shift.
// - Zero control digits with zero address act as no-operation.
// - Negative-check order stops the machine when the sum is negative.
// - Shift right copies the sign digit into vacated high positions.
// - Tape in and out combine with shift or cycle right.
// - One timing flip-flop selects fetch cycle or execute cycle.
// - End-carry pulse after every cycle that does not halt complements the timing flip-flop; a halt clears it.
// - Open end-carry path advances only on single or sweep pulses.
// - Low five transfer digits count down remaining shift steps.
// - Sum register is sixteen digits wide.
`timescale 1ns/10ps
module odtc_top (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  // Register port
  input  wire logic [odtc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [odtc_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [odtc_pkg::DATA_W-1:0]  o_rdata,
  output logic                              o_irq,
  // Storage selection switch
  output logic      [odtc_pkg::PC_W-1:0]    o_mem_addr,
  output logic                              o_mem_rd,
  output logic                              o_mem_wr,
  output logic      [odtc_pkg::WORD_W-1:0]  o_mem_wdata,
  input  wire logic                         i_mem_ack,
  input  wire logic [odtc_pkg::WORD_W-1:0]  i_mem_rdata,
  // Tape, display and test control
  input  wire logic [odtc_pkg::CHAR_W-1:0]  i_tape_char,
  output logic      [odtc_pkg::CHAR_W-1:0]  o_tape_char,
  output logic                              o_tape_strobe,
  output logic      [odtc_pkg::WORD_W-1:0]  o_disp_word,
  output logic                              o_disp_strobe,
  input  wire logic                         i_sweep_pulse,
  output logic                              o_halted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  odtc_pkg::odtc_state_t             state_ff;
  odtc_pkg::odtc_state_t             nxt_state;
  logic [odtc_pkg::PC_W-1:0]         pc_ff;
  logic [odtc_pkg::WORD_W-1:0]       sum_ff;
  logic [odtc_pkg::WORD_W-1:0]       xfer_ff;
  logic [odtc_pkg::WORD_W-1:0]       order_ff;
  logic                              phase_ff;
  logic                              halted_ff;
  logic                              run_ff;
  logic                              open_ff;
  logic                              pulse_cmd_ff;
  logic [odtc_pkg::INT_W-1:0]        int_stat_ff;
  logic [odtc_pkg::INT_W-1:0]        int_mask_ff;
  logic                              sw_meta_ff;
  logic                              sw_sync_ff;
  logic                              sw_prev_ff;

  logic                              sweep_edge;
  logic                              advance;
  logic                              sum_neg;
  logic                              take_jump;
  logic                              stop_now;
  logic                              check_stop;
  logic                              shift_done;
  logic                              wr_ctl;
  logic [odtc_pkg::INT_W-1:0]        int_set;
  logic [odtc_pkg::WORD_W-1:0]       operand;
  logic [odtc_pkg::WORD_W-1:0]       base_sum;

  odtc_dec_if dif ();

  odtc_decoder u_dec (
    .dif (dif)
  );

  assign dif.order = order_ff;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  assign sum_neg    = sum_ff[odtc_pkg::SIGN_BIT];
  assign sweep_edge = sw_sync_ff & ~sw_prev_ff;
  // Held cycle moves on only by a push-button or sweep pulse
  assign advance    = pulse_cmd_ff | sweep_edge;
  assign check_stop = dif.negative_check_halt & sum_neg;
  assign stop_now   = dif.halt_order | check_stop;
  assign take_jump  = dif.subprogram_jump
                      | (dif.conditional_jump & sum_neg);
  assign shift_done = (xfer_ff[odtc_pkg::CNT_W-1:0] == 5'h00);
  assign wr_ctl     = i_wr & (i_addr == odtc_pkg::REG_CONTROL);
  assign operand    = dif.minus ? (~xfer_ff + 16'h0001) : xfer_ff;
  assign base_sum   = dif.clear_sum ? odtc_pkg::WORD_RESET : sum_ff;

  // ----------------------------------------------------------------
  // Sweep pulse synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sw_meta_ff <= 1'b0;
      sw_sync_ff <= 1'b0;
      sw_prev_ff <= 1'b0;
    end else begin
      sw_meta_ff <= i_sweep_pulse;
      sw_sync_ff <= sw_meta_ff;
      sw_prev_ff <= sw_sync_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      odtc_pkg::ST_IDLE: begin
        if (run_ff && !halted_ff) begin
          // Timing flip-flop picks the kind of cycle
          nxt_state = phase_ff ? odtc_pkg::ST_OPER : odtc_pkg::ST_FETCH;
        end
      end
      odtc_pkg::ST_FETCH: nxt_state = odtc_pkg::ST_FWAIT;
      odtc_pkg::ST_FWAIT: begin
        if (i_mem_ack) begin
          nxt_state = odtc_pkg::ST_END;
        end
      end
      odtc_pkg::ST_OPER: begin
        nxt_state = dif.storage ? odtc_pkg::ST_OWAIT : odtc_pkg::ST_EXEC;
      end
      odtc_pkg::ST_OWAIT: begin
        if (i_mem_ack && !dif.store_low && dif.read_in) begin
          nxt_state = odtc_pkg::ST_EXEC;
        end else if (i_mem_ack) begin
          nxt_state = odtc_pkg::ST_EXEC;
        end
      end
      odtc_pkg::ST_EXEC: begin
        if (stop_now) begin
          nxt_state = odtc_pkg::ST_IDLE;
        end else if (dif.shift_right || dif.cycle_right) begin
          nxt_state = odtc_pkg::ST_SHIFT;
        end else begin
          nxt_state = odtc_pkg::ST_END;
        end
      end
      odtc_pkg::ST_SHIFT: begin
        if (shift_done) begin
          nxt_state = odtc_pkg::ST_END;
        end
      end
      odtc_pkg::ST_END: begin
        // End-carry returns through test control
        nxt_state = open_ff ? odtc_pkg::ST_HOLD : odtc_pkg::ST_IDLE;
      end
      odtc_pkg::ST_HOLD: begin
        if (advance) begin
          nxt_state = odtc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = odtc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= odtc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Timing flip-flop and halt
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_ff  <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      if ((state_ff == odtc_pkg::ST_END && !open_ff)
          || (state_ff == odtc_pkg::ST_HOLD && advance)) begin
        phase_ff <= ~phase_ff;
      end
      if (state_ff == odtc_pkg::ST_EXEC && stop_now) begin
        // Halting leaves the next cycle a fetch
        phase_ff  <= 1'b0;
        halted_ff <= 1'b1;
      end else if (wr_ctl && i_wdata[odtc_pkg::CTL_RUN_BIT]) begin
        halted_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_ff <= odtc_pkg::PC_RESET;
    end else if (wr_ctl && i_wdata[odtc_pkg::CTL_CLRPC_BIT]) begin
      pc_ff <= odtc_pkg::PC_RESET;
    end else if (state_ff == odtc_pkg::ST_FWAIT && i_mem_ack) begin
      pc_ff <= pc_ff + 10'h001;
    end else if (state_ff == odtc_pkg::ST_EXEC && take_jump) begin
      pc_ff <= xfer_ff[odtc_pkg::PC_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Datapath: order, transfer and sum registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      order_ff <= odtc_pkg::WORD_RESET;
      xfer_ff  <= odtc_pkg::WORD_RESET;
      sum_ff   <= odtc_pkg::WORD_RESET;
    end else begin
      case (state_ff)
        odtc_pkg::ST_FWAIT: begin
          if (i_mem_ack) begin
            order_ff <= i_mem_rdata;
          end
        end
        odtc_pkg::ST_OPER: begin
          // Address digits feed jumps and the step counter
          xfer_ff <= order_ff;
        end
        odtc_pkg::ST_OWAIT: begin
          if (i_mem_ack) begin
            xfer_ff <= i_mem_rdata;
          end
        end
        odtc_pkg::ST_EXEC: begin
          if (dif.read_in && !dif.display) begin
            sum_ff <= base_sum + operand;
          end else if (dif.storage && dif.clear_sum) begin
            sum_ff <= odtc_pkg::WORD_RESET;
          end else if (dif.tape_in && !stop_now) begin
            // Character enters low digits, then moves up
            sum_ff[odtc_pkg::CHAR_W-1:0] <= i_tape_char;
          end
        end
        odtc_pkg::ST_SHIFT: begin
          if (!shift_done) begin
            xfer_ff[odtc_pkg::CNT_W-1:0] <=
              xfer_ff[odtc_pkg::CNT_W-1:0] - 5'h01;
            if (dif.shift_right) begin
              sum_ff <= {sum_ff[odtc_pkg::SIGN_BIT],
                         sum_ff[odtc_pkg::WORD_W-1:1]};
            end else begin
              sum_ff <= {sum_ff[0], sum_ff[odtc_pkg::WORD_W-1:1]};
            end
          end
        end
        default: begin
          if (i_wr && i_addr == odtc_pkg::REG_SUM) begin
            sum_ff <= i_wdata[odtc_pkg::WORD_W-1:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mem_addr  <= odtc_pkg::PC_RESET;
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= odtc_pkg::WORD_RESET;
    end else begin
      o_mem_wr <= 1'b0;
      if (state_ff == odtc_pkg::ST_FETCH) begin
        o_mem_addr <= pc_ff;
        o_mem_rd   <= 1'b1;
      end else if (state_ff == odtc_pkg::ST_OPER && dif.storage) begin
        o_mem_addr <= order_ff[odtc_pkg::PC_W-1:0];
        o_mem_rd   <= 1'b1;
      end else if (i_mem_ack) begin
        o_mem_rd <= 1'b0;
      end
      if (state_ff == odtc_pkg::ST_EXEC && dif.storage
          && !dif.read_in) begin
        o_mem_wr <= 1'b1;
        // Short store keeps the high digits of the old word
        o_mem_wdata <= dif.store_low
          ? {xfer_ff[odtc_pkg::WORD_W-1:odtc_pkg::PC_W],
             sum_ff[odtc_pkg::PC_W-1:0]}
          : sum_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tape and display outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tape_char   <= 6'h00;
      o_tape_strobe <= 1'b0;
      o_disp_word   <= odtc_pkg::WORD_RESET;
      o_disp_strobe <= 1'b0;
    end else begin
      o_tape_strobe <= 1'b0;
      o_disp_strobe <= 1'b0;
      if (state_ff == odtc_pkg::ST_EXEC && dif.tape_out && !stop_now) begin
        o_tape_char   <= sum_ff[odtc_pkg::CHAR_W-1:0];
        o_tape_strobe <= 1'b1;
      end
      if (state_ff == odtc_pkg::ST_EXEC && dif.display) begin
        o_disp_word   <= xfer_ff;
        o_disp_strobe <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      run_ff       <= 1'b0;
      open_ff      <= 1'b0;
      pulse_cmd_ff <= 1'b0;
    end else begin
      pulse_cmd_ff <= wr_ctl & i_wdata[odtc_pkg::CTL_PULSE_BIT];
      if (wr_ctl) begin
        run_ff  <= i_wdata[odtc_pkg::CTL_RUN_BIT];
        open_ff <= i_wdata[odtc_pkg::CTL_OPEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    int_set = odtc_pkg::INT_RESET;
    if (state_ff == odtc_pkg::ST_EXEC) begin
      int_set[odtc_pkg::INT_HALT_BIT]  = stop_now;
      int_set[odtc_pkg::INT_CHECK_BIT] = check_stop;
      int_set[odtc_pkg::INT_TAPE_BIT]  = dif.tape_out & ~stop_now;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      int_stat_ff <= odtc_pkg::INT_RESET;
      int_mask_ff <= odtc_pkg::INT_RESET;
      o_irq       <= 1'b0;
    end else begin
      // A new event outranks a clear in the same cycle
      if (i_wr && i_addr == odtc_pkg::REG_INT_STAT) begin
        int_stat_ff <= (int_stat_ff & ~i_wdata[odtc_pkg::INT_W-1:0])
                       | int_set;
      end else begin
        int_stat_ff <= int_stat_ff | int_set;
      end
      if (i_wr && i_addr == odtc_pkg::REG_INT_MASK) begin
        int_mask_ff <= i_wdata[odtc_pkg::INT_W-1:0];
      end
      o_irq <= |(int_stat_ff & int_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata  <= 32'h0000_0000;
      o_halted <= 1'b0;
    end else begin
      o_halted <= halted_ff;
      o_rdata  <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          odtc_pkg::REG_CONTROL:
            o_rdata <= {30'h0, open_ff, run_ff};
          odtc_pkg::REG_STATUS:
            o_rdata <= {29'h0, (state_ff == odtc_pkg::ST_HOLD),
                        halted_ff, phase_ff};
          odtc_pkg::REG_PC:
            o_rdata <= {22'h0, pc_ff};
          odtc_pkg::REG_SUM:
            o_rdata <= {16'h0, sum_ff};
          odtc_pkg::REG_TRANSFER:
            o_rdata <= {16'h0, xfer_ff};
          odtc_pkg::REG_ORDER:
            o_rdata <= {16'h0, order_ff};
          odtc_pkg::REG_INT_STAT:
            o_rdata <= {29'h0, int_stat_ff};
          odtc_pkg::REG_INT_MASK:
            o_rdata <= {29'h0, int_mask_ff};
          default:
            o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// File: core/odtc_pkg.sv
// Package of constants and types for the order decode and timing control.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package odtc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int PC_W    = 10;
  localparam int CTRL_W  = 6;
  localparam int CNT_W   = 5;
  localparam int CHAR_W  = 6;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CONTROL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PC        = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SUM       = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_TRANSFER  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ORDER     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_INT_MASK  = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN_BIT    = 0;
  localparam int CTL_OPEN_BIT   = 1;
  localparam int CTL_CLRPC_BIT  = 2;
  localparam int CTL_PULSE_BIT  = 3;
  localparam int STA_PHASE_BIT  = 0;
  localparam int STA_HALT_BIT   = 1;
  localparam int STA_HOLD_BIT   = 2;
  localparam int INT_HALT_BIT   = 0;
  localparam int INT_CHECK_BIT  = 1;
  localparam int INT_TAPE_BIT   = 2;
  localparam int INT_W          = 3;
  localparam int ORD_CTRL_LSB   = 10;
  localparam int SIGN_BIT       = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_RESET   = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [INT_W-1:0]  INT_RESET  = 3'h0;

  // ----------------------------------------------------------------
  // Control digit codes (digit 1 is the most significant bit)
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] OP_NONE      = 6'h00;
  localparam logic [CTRL_W-1:0] OP_NEG_CHECK = 6'h1c;
  localparam int D1 = 5;
  localparam int D2 = 4;
  localparam int D3 = 3;
  localparam int D4 = 2;
  localparam int D5 = 1;
  localparam int D6 = 0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_FETCH = 9'h002,
    ST_FWAIT = 9'h004,
    ST_OPER  = 9'h008,
    ST_OWAIT = 9'h010,
    ST_EXEC  = 9'h020,
    ST_SHIFT = 9'h040,
    ST_END   = 9'h080,
    ST_HOLD  = 9'h100
  } odtc_state_t;

endpackage

// File: core/odtc_dec_if.sv
// Interface carrying an order word to the decoder and its flags back.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface odtc_dec_if;
  logic [odtc_pkg::WORD_W-1:0] order;
  logic storage;
  logic read_in;
  logic minus;
  logic display;
  logic clear_sum;
  logic store_low;
  logic subprogram_jump;
  logic conditional_jump;
  logic negative_check_halt;
  logic tape_in;
  logic tape_out;
  logic shift_right;
  logic cycle_right;
  logic halt_order;
  logic nop_order;

  modport ctl (output order, input storage, read_in, minus, display,
               clear_sum, store_low, subprogram_jump, conditional_jump,
               negative_check_halt, tape_in, tape_out, shift_right,
               cycle_right, halt_order, nop_order);
  modport dec (input order, output storage, read_in, minus, display,
               clear_sum, store_low, subprogram_jump, conditional_jump,
               negative_check_halt, tape_in, tape_out, shift_right,
               cycle_right, halt_order, nop_order);
endinterface

// File: core/odtc_decoder.sv
// Combinational decoder of the six control digits of an order.
// Assumes the order word is held stable by the sequencer.
`timescale 1ns/10ps
module odtc_decoder (
  // Order and flags
  odtc_dec_if.dec dif
);

  logic [odtc_pkg::CTRL_W-1:0] cd;
  logic                        addr_zero;

  assign cd        = dif.order[odtc_pkg::WORD_W-1:odtc_pkg::ORD_CTRL_LSB];
  assign addr_zero = (dif.order[odtc_pkg::PC_W-1:0] == 10'h000);

  // ----------------------------------------------------------------
  // Digit-wise decode
  // ----------------------------------------------------------------
  always_comb begin
    dif.storage             = cd[odtc_pkg::D1];
    // Digit two low brings a word out of storage, high stores one
    dif.read_in             = cd[odtc_pkg::D1] & ~cd[odtc_pkg::D2];
    dif.minus               = dif.read_in & cd[odtc_pkg::D3];
    dif.display             = dif.read_in & cd[odtc_pkg::D4];
    dif.clear_sum           = cd[odtc_pkg::D1] & cd[odtc_pkg::D5];
    dif.store_low           = cd[odtc_pkg::D1] & cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D3];
    dif.negative_check_halt = (cd == odtc_pkg::OP_NEG_CHECK);
    dif.subprogram_jump     = ~cd[odtc_pkg::D1] & cd[odtc_pkg::D2]
                              & ~cd[odtc_pkg::D3];
    dif.conditional_jump    = ~cd[odtc_pkg::D1] & cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D3] & ~cd[odtc_pkg::D4];
    // Tape digits ride along with the shift digits
    dif.tape_in             = ~cd[odtc_pkg::D1] & ~cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D3];
    dif.tape_out            = ~cd[odtc_pkg::D1] & ~cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D4];
    dif.shift_right         = ~cd[odtc_pkg::D1] & ~cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D6] & cd[odtc_pkg::D5];
    dif.cycle_right         = ~cd[odtc_pkg::D1] & ~cd[odtc_pkg::D2]
                              & cd[odtc_pkg::D6] & ~cd[odtc_pkg::D5];
    // All-zero digits: halt on a live address, else pass on
    dif.halt_order          = (cd == odtc_pkg::OP_NONE) & ~addr_zero;
    dif.nop_order           = (cd == odtc_pkg::OP_NONE) & addr_zero;
  end

endmodule

// File: testbench/odtc_props.sv
// Checker of port timing for the order decode and timing control.
// Assumes it is bound to odtc_top and sees only the top module's ports.
`timescale 1ns/10ps
module odtc_props (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [7:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_mem_rd,
  input wire logic        i_mem_ack,
  input wire logic [9:0]  o_mem_addr,
  input wire logic        o_mem_wr,
  input wire logic        o_tape_strobe,
  input wire logic        o_halted,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_pc_w; i_rd && i_addr == 8'h08 |=> o_rdata[31:10] == 22'h0;
  endproperty
  a_pc_w: assert property (p_pc_w) else $error("counter too wide");
  property p_rd_hold; o_mem_rd && !i_mem_ack |=> o_mem_rd; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
  property p_rd_drop; o_mem_rd && i_mem_ack |=> !o_mem_rd; endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read held");
  property p_addr; o_mem_rd && !i_mem_ack |=> $stable(o_mem_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wr; o_mem_wr |=> !o_mem_wr; endproperty
  a_wr: assert property (p_wr) else $error("store not a pulse");
  property p_tape; o_tape_strobe |=> !o_tape_strobe; endproperty
  a_tape: assert property (p_tape) else $error("tape not a pulse");
  property p_halt; $rose(o_halted) |-> !o_mem_rd; endproperty
  a_halt: assert property (p_halt) else $error("halt during read");
  c_halt: cover property ($rose(o_halted));
  c_ack: cover property (o_mem_rd && i_mem_ack);
  c_irq: cover property ($rose(o_irq));
endmodule
bind odtc_top odtc_props u_props (.*);

// File: testbench/odtc_mem_model.sv
// Core memory stand-in: held read answered by a one-cycle ack.
// Assumes the same clock as the design; odd addresses answer slower.
`timescale 1ns/10ps
module odtc_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic [9:0]  i_addr,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:1023];
  logic [1:0]  wait_ff = 2'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 16'h0;
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // No stale word once released
    o_rdata <= ~o_rdata;
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd && !o_ack) wait_ff <= wait_ff + 2'h1;
    if (i_rd && !o_ack && wait_ff == {1'b0, i_addr[0]}) begin
      o_ack <= 1'b1;
      o_rdata <= mem[i_addr];
      wait_ff <= 2'h0;
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench: small programs run through odtc_top.
// Assumes odtc_mem_model stands in for core memory.
`timescale 1ns/10ps
module tb;
  logic clk, rst, wr, rd, ack, sweep, mrd, mwr, irq, halted, ts, ds;
  logic [7:0] addr;
  logic [31:0] wd, rdat, d;
  logic [9:0] maddr;
  logic [15:0] mrdat, mwd, dw, dq;
  logic [5:0] tch, tape_q;
  int error_cnt = 0;
  int cmp_count = 0;
  odtc_top u_dut (.i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_irq(irq), .o_mem_addr(maddr),
    .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_wdata(mwd), .i_mem_ack(ack),
    .i_mem_rdata(mrdat), .i_tape_char(6'h15), .o_tape_char(tch),
    .o_tape_strobe(ts), .o_disp_word(dw), .o_disp_strobe(ds),
    .i_sweep_pulse(sweep), .o_halted(halted));
  odtc_mem_model u_mem (.i_clk(clk), .i_rd(mrd), .i_addr(maddr),
    .i_wr(mwr), .i_wdata(mwd), .o_ack(ack), .o_rdata(mrdat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (ts) tape_q <= tch;
  always @(posedge clk) if (ds) dq <= dw;
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic r(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdat;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic halt_wait();
    for (int k = 0; k < 100 && d[1] !== 1'b1; k++) r(8'h04);
    chk("halted", 32'h1, {31'h0, halted});
  endtask
  task automatic t_prog();
    r(8'h08); chk("pc", 32'h0, d);
    r(8'h40); chk("unmapped", 32'h0, d);
    w(8'h0c, 32'h8004); w(8'h1c, 32'h1); w(8'h00, 32'h1);
    halt_wait();
    r(8'h08); chk("pc", 32'h22, d);
    r(8'h0c); chk("sum", 32'he002, d);
    chk("store", 32'h8009, {16'h0, u_mem.mem[10'h30]});
    chk("tape", 32'h9, {26'h0, tape_q});
    chk("irq", 32'h1, {31'h0, irq});
    w(8'h18, 32'h7); r(8'h18); chk("int", 32'h0, d);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test program done");
  endtask
  task automatic t_neg();
    d = 32'h0;
    w(8'h00, 32'h1); halt_wait();
    r(8'h18); chk("int", 32'h3, d);
    r(8'h08); chk("pc", 32'h23, d);
    $display("test check done");
  endtask
  task automatic t_step();
    w(8'h00, 32'h3); repeat (20) @(posedge clk);
    r(8'h04); chk("hold", 32'h1, {31'h0, d[2]});
    r(8'h08); chk("pc", 32'h24, d);
    w(8'h00, 32'hb); repeat (20) @(posedge clk);
    r(8'h08); chk("pc", 32'h24, d);
    sweep <= 1'b1;
    repeat (4) @(posedge clk) sweep <= 1'b0;
    repeat (20) @(posedge clk);
    r(8'h08); chk("pc", 32'h25, d);
    $display("test step done");
  endtask
  task automatic t_more();
    d = 32'h0;
    w(8'h00, 32'h9); halt_wait();
    r(8'h08); chk("pc", 32'h29, d);
    r(8'h0c); chk("sum", 32'h577b, d);
    chk("disp", 32'h5, {16'h0, dq});
    $display("test decode done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst, wr, rd, sweep, addr, wd} = {3'h4, 41'h0};
    u_mem.mem[0] = 16'h0000;
    u_mem.mem[1] = 16'h8010;
    u_mem.mem[2] = 16'hc030;
    u_mem.mem[3] = 16'h4020;
    u_mem.mem[16] = 16'h0005;
    u_mem.mem[32] = 16'h1c02;
    u_mem.mem[33] = 16'h0001;
    u_mem.mem[34] = 16'h7000;
    u_mem.mem[35] = 16'h0000;
    u_mem.mem[36] = 16'h9010;
    u_mem.mem[37] = 16'h2406;
    u_mem.mem[38] = 16'h6030;
    u_mem.mem[39] = 16'ha010;
    u_mem.mem[40] = 16'h0001;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_prog();
    t_neg();
    t_step();
    t_more();
    final_report();
  end
  initial begin
    #100000 error_cnt++;
    final_report();
  end
endmodule
